// file: mbs_server.sv
`timescale 1ns/1ps
module mbs_server (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // configuration
  input wire logic [7:0] station_id,
  // point pins
  input wire logic [7:0] coil_state_in,
  input wire logic [7:0] input_pin,
  // request byte stream
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  output logic rx_ready,
  // response byte stream
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  input wire logic tx_ready,
  // hand-off of other recognised commands, and request drop pulse
  output logic cmd_other_valid,
  output logic [7:0] cmd_other_code,
  output logic req_drop
);

  // ************************************************************
  // declarations
  // ************************************************************
  mbs_pkg::mbs_state_t state_reg;
  mbs_pkg::mbs_req_t req_reg;
  logic [7:0] rx_cnt_reg;
  logic [7:0] len_reg;
  logic [7:0] coil_sync;
  logic [7:0] din_sync;
  logic [7:0] pts_reg;
  logic [15:0] base_reg;
  logic [8:0] tx_idx_reg;
  logic [8:0] nidx;
  logic [8:0] tx_total;
  logic [8:0] data_off;
  logic [7:0] bc_now;
  logic [7:0] pack_byte;
  logic rx_take;
  logic tx_take;
  logic unit_ok;
  logic is_bit_read;
  logic resp_ok;
  logic other_ok;

  // ************************************************************
  // pin synchronisers and bit packer
  // ************************************************************
  mbs_sync #(
    .W(16)
  ) u_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .async_in({coil_state_in, input_pin}),
    .sync_out({coil_sync, din_sync})
  );

  assign data_off = nidx - mbs_pkg::RSP_FIXED;

  mbs_bit_pack u_pack (
    .points(pts_reg),
    .start(req_reg.start),
    .base(base_reg),
    .count(req_reg.count),
    .byte_idx(data_off[7:0]),
    .data(pack_byte)
  );

  // ************************************************************
  // decode
  // ************************************************************
  function automatic logic [7:0] rsp_byte(
    input logic [8:0] idx,
    input mbs_pkg::mbs_req_t r,
    input logic [7:0] bc,
    input logic [7:0] dat
  );
    logic [15:0] rlen;
    rlen = mbs_pkg::RSP_LEN_BASE + {8'h00, bc};
    case (idx)
      9'h000: return r.tid[15:8]; // RULE_03
      9'h001: return r.tid[7:0];
      9'h002: return r.pid[15:8];
      9'h003: return r.pid[7:0];
      9'h004: return rlen[15:8];
      9'h005: return rlen[7:0];
      9'h006: return r.unit; // RULE_04
      9'h007: return r.fc; // RULE_07 RULE_10
      9'h008: return bc; // RULE_18
      default: return dat; // RULE_05 RULE_08
    endcase
  endfunction

  assign rx_ready = (state_reg == mbs_pkg::ST_LISTEN); // RULE_01
  assign rx_take = rx_valid && rx_ready;
  assign tx_take = tx_valid && tx_ready;
  assign bc_now = mbs_pkg::mbs_byte_count(req_reg.count);
  assign tx_total = mbs_pkg::RSP_FIXED + {1'b0, bc_now};
  assign nidx = (state_reg == mbs_pkg::ST_SEND) ? tx_idx_reg + 9'h001
                                                : 9'h000;
  assign unit_ok = (req_reg.unit == station_id); // RULE_04
  assign is_bit_read = (req_reg.fc == mbs_pkg::FC_RD_COIL) ||
                       (req_reg.fc == mbs_pkg::FC_RD_INPUT);
  assign resp_ok = unit_ok && is_bit_read &&
                   (len_reg >= mbs_pkg::REQ_LEN) &&
                   (req_reg.count >= mbs_pkg::COUNT_MIN) &&
                   (req_reg.count <= mbs_pkg::COUNT_MAX); // RULE_19
  assign other_ok = unit_ok && mbs_pkg::mbs_is_other(req_reg.fc) &&
                    (len_reg >= mbs_pkg::FC_MIN_LEN);

  // ************************************************************
  // state machine
  // ************************************************************
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= mbs_pkg::ST_LISTEN;
    end
    else
    begin
      case (state_reg)
        mbs_pkg::ST_LISTEN:
        begin
          if (rx_take && rx_last)
          begin
            state_reg <= mbs_pkg::ST_CHECK;
          end
        end
        mbs_pkg::ST_CHECK:
        begin
          state_reg <= resp_ok ? mbs_pkg::ST_SEND
                               : mbs_pkg::ST_LISTEN; // RULE_19
        end
        mbs_pkg::ST_SEND:
        begin
          if (tx_take && tx_last)
          begin
            state_reg <= mbs_pkg::ST_LISTEN; // RULE_01
          end
        end
        default:
        begin
          state_reg <= mbs_pkg::ST_LISTEN;
        end
      endcase
    end
  end

  // ************************************************************
  // request capture
  // ************************************************************
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      req_reg <= '0;
      rx_cnt_reg <= '0;
      len_reg <= '0;
    end
    else if (rx_take)
    begin
      case (rx_cnt_reg)
        8'h00: req_reg.tid[15:8] <= rx_data; // RULE_03
        8'h01: req_reg.tid[7:0] <= rx_data;
        8'h02: req_reg.pid[15:8] <= rx_data;
        8'h03: req_reg.pid[7:0] <= rx_data;
        8'h06: req_reg.unit <= rx_data; // RULE_04
        8'h07: req_reg.fc <= rx_data;
        8'h08: req_reg.start[15:8] <= rx_data;
        8'h09: req_reg.start[7:0] <= rx_data;
        8'h0A: req_reg.count[15:8] <= rx_data;
        8'h0B: req_reg.count[7:0] <= rx_data;
        default: req_reg <= req_reg;
      endcase
      if (rx_last)
      begin
        rx_cnt_reg <= '0;
        len_reg <= (rx_cnt_reg == mbs_pkg::RX_CNT_MAX) ? rx_cnt_reg
                                                       : rx_cnt_reg + 8'h01;
      end
      else if (rx_cnt_reg != mbs_pkg::RX_CNT_MAX)
      begin
        rx_cnt_reg <= rx_cnt_reg + 8'h01;
      end
    end
  end

  // ************************************************************
  // point snapshot
  // ************************************************************
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pts_reg <= '0;
      base_reg <= mbs_pkg::INPUT_BASE;
    end
    else if (state_reg == mbs_pkg::ST_CHECK)
    begin
      if (req_reg.fc == mbs_pkg::FC_RD_COIL)
      begin
        pts_reg <= coil_sync; // RULE_05
        base_reg <= mbs_pkg::COIL_BASE; // RULE_12
      end
      else
      begin
        pts_reg <= din_sync; // RULE_08
        base_reg <= mbs_pkg::INPUT_BASE; // RULE_13
      end
    end
  end

  // ************************************************************
  // response stream
  // ************************************************************
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_valid <= 1'b0;
      tx_data <= mbs_pkg::RST_BYTE;
      tx_last <= 1'b0;
      tx_idx_reg <= '0;
    end
    else if (state_reg == mbs_pkg::ST_CHECK && resp_ok)
    begin
      tx_valid <= 1'b1;
      tx_idx_reg <= nidx;
      tx_data <= rsp_byte(nidx, req_reg, bc_now, pack_byte); // RULE_03
      tx_last <= 1'b0;
    end
    else if (state_reg == mbs_pkg::ST_SEND && tx_take)
    begin
      if (tx_last)
      begin
        tx_valid <= 1'b0;
        tx_last <= 1'b0;
      end
      else
      begin
        tx_idx_reg <= nidx;
        tx_data <= rsp_byte(nidx, req_reg, bc_now, pack_byte); // RULE_07
        tx_last <= (nidx == tx_total - 9'h001); // RULE_10
      end
    end
  end

  // ************************************************************
  // other commands and drops
  // ************************************************************
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cmd_other_valid <= 1'b0;
      cmd_other_code <= mbs_pkg::RST_BYTE;
      req_drop <= 1'b0;
    end
    else
    begin
      cmd_other_valid <= (state_reg == mbs_pkg::ST_CHECK) && other_ok;
      req_drop <= (state_reg == mbs_pkg::ST_CHECK) && !resp_ok &&
                  !other_ok; // RULE_19
      if (state_reg == mbs_pkg::ST_CHECK && other_ok)
      begin
        cmd_other_code <= req_reg.fc; // RULE_14 RULE_15 RULE_16 RULE_17
      end
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence seq_last_beat;
    tx_valid && tx_ready && tx_last;
  endsequence

  sequence seq_reject;
    (state_reg == mbs_pkg::ST_CHECK) && !resp_ok;
  endsequence

  AST_NO_RX_WHILE_TX: // RULE_01
    assert property (tx_valid |-> !rx_ready)
    else $error("request accepted while answering");

  AST_LISTEN_AFTER_TX: // RULE_01
    assert property (seq_last_beat |=> rx_ready && !tx_valid)
    else $error("not listening after last response byte");

  AST_HDR_FIRST: // RULE_03
    assert property ($rose(tx_valid) |-> tx_data == req_reg.tid[15:8])
    else $error("response does not open with transaction id");

  AST_UNIT_ECHO: // RULE_04
    assert property (tx_valid && tx_idx_reg == mbs_pkg::IDX_UNIT
                     |-> tx_data == station_id)
    else $error("station byte wrong");

  AST_FC_ECHO: // RULE_07
    assert property (tx_valid && tx_idx_reg == mbs_pkg::IDX_FC
                     |-> tx_data == req_reg.fc && is_bit_read)
    else $error("function byte wrong");

  AST_BYTE_COUNT: // RULE_18
    assert property (tx_valid && tx_idx_reg == mbs_pkg::IDX_BC
                     |-> tx_data == 8'((req_reg.count + 16'h0007) >> 3))
    else $error("byte count wrong");

  AST_LEN_FIELD: // RULE_10
    assert property (tx_valid && tx_idx_reg == mbs_pkg::IDX_LEN_LO
                     |-> tx_data == 8'(bc_now + 8'h03))
    else $error("length field wrong");

  AST_COIL_MAP: // RULE_12
    assert property (tx_valid && tx_idx_reg == mbs_pkg::RSP_FIXED &&
                     req_reg.fc == mbs_pkg::FC_RD_COIL &&
                     req_reg.start == 16'h0011 && req_reg.count == 16'h0008
                     |-> tx_data == pts_reg)
    else $error("coil mapping wrong");

  AST_INPUT_MAP: // RULE_13
    assert property (tx_valid && tx_idx_reg == mbs_pkg::RSP_FIXED &&
                     req_reg.fc == mbs_pkg::FC_RD_INPUT &&
                     req_reg.start == 16'h0001 && req_reg.count == 16'h0008
                     |-> tx_data == pts_reg)
    else $error("input mapping wrong");

  AST_NO_ANSWER: // RULE_19
    assert property (seq_reject |=> (!tx_valid && rx_ready) [*2])
    else $error("rejected request answered");

  AST_OTHER_CODE: // RULE_14
    assert property (cmd_other_valid |-> mbs_pkg::mbs_is_other(cmd_other_code)
                     && !tx_valid)
    else $error("bad hand-off code");

  AST_STALL_HOLD: // RULE_07
    assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)
                     && $stable(tx_last))
    else $error("response byte changed under stall");

  AST_LAST_INDEX: // RULE_10
    assert property (seq_last_beat |-> tx_idx_reg == tx_total - 9'h001)
    else $error("response length wrong");

endmodule // mbs_server

// file: mbs_pkg.sv
// Function
// RULE_01: outside a response the server listens for the next host command.
// RULE_02: host addresses one station per command and times out without answer.
// RULE_03: every frame is a six byte header followed by the body.
// RULE_04: body byte one is the station address, byte two the function code.
// RULE_05: code 01 reports the on/off state of the output coils.
// RULE_06: code 01 request: station, code, start high/low, count high/low.
// RULE_07: code 01 answer: station, code, byte count, then the data bytes.
// RULE_08: code 02 reports the on/off state of the discrete inputs.
// RULE_09: code 02 request: station, code, start high/low, count high/low.
// RULE_10: code 02 answer: station, code, byte count, then the data bytes.
// RULE_11: each data byte packs eight consecutive points, a one means on.
// RULE_12: coils one to eight sit at protocol addresses 00017 to 00024.
// RULE_13: inputs one to eight sit at protocol addresses 00001 to 00008.
// RULE_14: codes 03 and 04 are taken as 16-bit register reads.
// RULE_15: code 05 is taken as a single coil force.
// RULE_16: code 08 is taken as a loopback diagnostic request.
// RULE_17: code 15 is taken as a multiple coil force.
// RULE_18: byte count is points over eight rounded up, lowest point bit zero.
// RULE_19: wrong station or unknown code gets no answer, back to listening.
package mbs_pkg;

  // ************************************************************
  // frame layout
  // ************************************************************
  localparam logic [7:0] REQ_LEN = 8'h0C;
  localparam logic [7:0] FC_MIN_LEN = 8'h08;
  localparam logic [7:0] RX_CNT_MAX = 8'hFF;
  localparam logic [8:0] IDX_LEN_LO = 9'h005;
  localparam logic [8:0] IDX_UNIT = 9'h006;
  localparam logic [8:0] IDX_FC = 9'h007;
  localparam logic [8:0] IDX_BC = 9'h008;
  localparam logic [8:0] RSP_FIXED = 9'h009;
  localparam logic [15:0] RSP_LEN_BASE = 16'h0003;

  // ************************************************************
  // function codes
  // ************************************************************
  localparam logic [7:0] FC_RD_COIL = 8'h01;
  localparam logic [7:0] FC_RD_INPUT = 8'h02;
  localparam logic [7:0] FC_RD_HOLD = 8'h03;
  localparam logic [7:0] FC_RD_INREG = 8'h04;
  localparam logic [7:0] FC_FORCE_ONE = 8'h05;
  localparam logic [7:0] FC_LOOPBACK = 8'h08;
  localparam logic [7:0] FC_FORCE_MANY = 8'h0F;

  // ************************************************************
  // point map and limits
  // ************************************************************
  localparam logic [15:0] COIL_BASE = 16'h0011;
  localparam logic [15:0] INPUT_BASE = 16'h0001;
  localparam logic [15:0] COUNT_MIN = 16'h0001;
  localparam logic [15:0] COUNT_MAX = 16'h07D0;
  localparam logic [15:0] COUNT_ROUND = 16'h0007;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // ************************************************************
  // types
  // ************************************************************
  typedef struct packed {
    logic [15:0] tid;
    logic [15:0] pid;
    logic [7:0] unit;
    logic [7:0] fc;
    logic [15:0] start;
    logic [15:0] count;
  } mbs_req_t;

  typedef enum logic [2:0] {
    ST_LISTEN = 3'b001,
    ST_CHECK = 3'b010,
    ST_SEND = 3'b100
  } mbs_state_t;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [7:0] mbs_byte_count(input logic [15:0] cnt);
    logic [15:0] s;
    s = cnt + COUNT_ROUND;
    return s[10:3]; // RULE_18
  endfunction

  function automatic logic mbs_is_other(input logic [7:0] fc);
    return (fc == FC_RD_HOLD) || (fc == FC_RD_INREG) || // RULE_14
           (fc == FC_FORCE_ONE) || // RULE_15
           (fc == FC_LOOPBACK) || // RULE_16
           (fc == FC_FORCE_MANY); // RULE_17
  endfunction

endpackage

// file: mbs_sync.sv
`timescale 1ns/1ps
module mbs_sync #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // mbs_sync

// file: mbs_bit_pack.sv
`timescale 1ns/1ps
module mbs_bit_pack (
  // point states
  input wire logic [7:0] points,
  // request window
  input wire logic [15:0] start,
  input wire logic [15:0] base,
  input wire logic [15:0] count,
  input wire logic [7:0] byte_idx,
  // packed byte
  output logic [7:0] data
);

  always_comb
  begin
    logic [10:0] off;
    logic [16:0] pos;
    logic [16:0] rel;
    off = '0;
    pos = '0;
    rel = '0;
    data = '0;
    for (int j = 0; j < 8; j++)
    begin
      off = {byte_idx, 3'(j)};
      pos = {1'b0, start} + {6'b00_0000, off};
      rel = pos - {1'b0, base};
      // points outside the window or past the count read as zero
      if (pos >= {1'b0, base} && rel < 17'h0_0008 &&
          {5'b0_0000, off} < count)
      begin
        data[j] = points[rel[2:0]]; // RULE_11 RULE_18
      end
    end
  end

endmodule // mbs_bit_pack

// file: mbs_host_model.sv
`timescale 1ns/1ps
module mbs_host_model (
  // clock
  input wire logic core_clk,
  // request stream
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_last,
  input wire logic rx_ready,
  // response stream
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready,
  // outcome pulses
  input wire logic cmd_other_valid,
  input wire logic req_drop
);
  logic [7:0] rsp[$];
  logic got_other;
  logic got_drop;
  logic stall;

  initial
  begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_last = 1'b0;
    tx_ready = 1'b1;
    stall = 1'b0;
    got_other = 1'b0;
    got_drop = 1'b0;
  end

  // ************************************************************
  // one exchange: send a frame, then wait a bounded time
  // ************************************************************
  task automatic xfer(input logic [7:0] frm[$]);
    int lim;
    logic done;
    rsp = {};
    got_other = 1'b0;
    got_drop = 1'b0;
    lim = 600;
    done = 1'b0;
    @(posedge core_clk);
    foreach (frm[i])
    begin
      rx_valid <= 1'b1;
      rx_data <= frm[i];
      rx_last <= (i == frm.size() - 1);
      do @(posedge core_clk); while (rx_ready !== 1'b1);
    end
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    // released data line does not keep its last value
    rx_data <= ~frm[frm.size() - 1];
    for (int n = 0; n < lim && !done; n++)
    begin
      tx_ready <= stall ? ($urandom_range(3) != 0) : 1'b1;
      @(posedge core_clk);
      if (tx_valid === 1'b1 && tx_ready === 1'b1)
      begin
        rsp.push_back(tx_data);
        done = (tx_last === 1'b1);
      end
      // after a pulse keep watching briefly for a stray answer
      if ((cmd_other_valid === 1'b1 || req_drop === 1'b1) && lim == 600)
        lim = n + 8;
      if (cmd_other_valid === 1'b1)
        got_other = 1'b1;
      if (req_drop === 1'b1)
        got_drop = 1'b1;
    end
  endtask
endmodule // mbs_host_model

// file: testbench.sv
`timescale 1ns/1ps
`define CHK(a, b, m) \
  tests_run++; \
  if ((a) !== (b)) \
  begin \
    n_errors++; \
    $display("[FAIL] %0t %s", $time, m); \
  end
module testbench;
  logic core_clk;
  logic reset_n;
  logic [7:0] station_id;
  logic [7:0] coil_state_in;
  logic [7:0] input_pin;
  logic rx_valid;
  logic [7:0] rx_data;
  logic rx_last;
  logic rx_ready;
  logic tx_valid;
  logic [7:0] tx_data;
  logic tx_last;
  logic tx_ready;
  logic cmd_other_valid;
  logic [7:0] cmd_other_code;
  logic req_drop;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [7:0] frm[$];
  logic [7:0] exp[$];
  logic [7:0] codes[5] = '{8'h03, 8'h04, 8'h05, 8'h08, 8'h0F};

  mbs_server u_mbs_server (
    .core_clk(core_clk), .reset_n(reset_n), .station_id(station_id),
    .coil_state_in(coil_state_in), .input_pin(input_pin),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_ready(tx_ready),
    .cmd_other_valid(cmd_other_valid), .cmd_other_code(cmd_other_code),
    .req_drop(req_drop)
  );

  mbs_host_model u_mbs_host_model (
    .core_clk(core_clk), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_last(rx_last), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
    .cmd_other_valid(cmd_other_valid), .req_drop(req_drop)
  );

  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      n_errors++;
      close_out();
    end
  end

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic close_out();
    if (n_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  function automatic logic [7:0] pack(input logic [7:0] st,
    input logic [15:0] base, input logic [15:0] start,
    input logic [15:0] count, input int k);
    logic [7:0] b;
    int p;
    int a;
    b = 8'h00;
    for (int j = 0; j < 8; j++)
    begin
      p = 8 * k + j;
      a = int'(start) + p;
      if (p < int'(count) && a >= int'(base) && a < int'(base) + 8)
        b[j] = st[a - int'(base)];
    end
    return b;
  endfunction

  task automatic mk(input logic [15:0] tid, input logic [7:0] unit,
    input logic [7:0] fc, input logic [15:0] start,
    input logic [15:0] count, input int len);
    frm = {tid[15:8], tid[7:0], 8'h00, 8'h00, 8'h00, 8'h06, unit, fc,
      start[15:8], start[7:0], count[15:8], count[7:0]};
    while (frm.size() > len)
      void'(frm.pop_back());
  endtask

  task automatic run_read(input logic [7:0] fc, input logic [15:0] start,
    input logic [15:0] count, input logic [7:0] cs, input logic [7:0] ip);
    logic [15:0] tid;
    logic [15:0] len;
    int bc;
    tid = 16'($urandom);
    bc = (int'(count) + 7) / 8;
    len = 16'(3 + bc);
    @(posedge core_clk);
    coil_state_in <= cs;
    input_pin <= ip;
    mk(tid, station_id, fc, start, count, 12);
    exp = {tid[15:8], tid[7:0], 8'h00, 8'h00, len[15:8], len[7:0],
      station_id, fc, 8'(bc)};
    for (int k = 0; k < bc; k++)
      if (fc == 8'h01)
        exp.push_back(pack(cs, 16'h0011, start, count, k));
      else
        exp.push_back(pack(ip, 16'h0001, start, count, k));
    u_mbs_host_model.stall = 1'($urandom);
    u_mbs_host_model.xfer(frm);
    #1;
    `CHK(u_mbs_host_model.rsp.size(), exp.size(), "answer length");
    foreach (exp[i])
    begin
      `CHK(u_mbs_host_model.rsp[i], exp[i], "answer byte");
    end
    `CHK(u_mbs_host_model.got_drop, 1'b0, "read dropped");
    `CHK(rx_ready, 1'b1, "not listening after answer");
  endtask

  task automatic run_silent(input logic other, input logic [7:0] fc);
    u_mbs_host_model.xfer(frm);
    #1;
    `CHK(u_mbs_host_model.rsp.size(), 0, "unexpected answer");
    `CHK(u_mbs_host_model.got_other, other, "hand-off pulse");
    `CHK(u_mbs_host_model.got_drop, !other, "drop pulse");
    if (other)
    begin
      `CHK(cmd_other_code, fc, "hand-off code");
    end
    `CHK(rx_ready, 1'b1, "not listening after silence");
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    void'($urandom(32'h6f08));
    reset_n = 1'b0;
    station_id = 8'(($urandom % 8'hfe) + 1);
    coil_state_in = 8'h00;
    input_pin = 8'h00;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    run_read(8'h01, 16'h0011, 16'h0008, 8'h42, 8'h00);
    run_read(8'h02, 16'h0001, 16'h0008, 8'h00, 8'h60);
    run_read(8'h02, 16'h0000, 16'h0009, 8'hff, 8'hff);
    run_read(8'h01, 16'h0018, 16'h0001, 8'h80, 8'h00);
    run_read(8'h01, 16'h0011, 16'h07D0, 8'hA5, 8'h5A);
    for (int i = 0; i < 40; i++)
      run_read(8'(1 + $urandom_range(1)), 16'($urandom_range(24)),
        16'(1 + $urandom_range(23)), 8'($urandom), 8'($urandom));
    foreach (codes[i])
    begin
      mk(16'h0100, station_id, codes[i], 16'h0001, 16'h0001, 12);
      run_silent(1'b1, codes[i]);
    end
    mk(16'h0200, station_id + 8'h01, 8'h01, 16'h0011, 16'h0008, 12);
    run_silent(1'b0, 8'h00);
    mk(16'h0201, station_id, 8'h06, 16'h0011, 16'h0008, 12);
    run_silent(1'b0, 8'h00);
    mk(16'h0202, station_id, 8'h01, 16'h0011, 16'h0000, 12);
    run_silent(1'b0, 8'h00);
    mk(16'h0203, station_id, 8'h02, 16'h0001, 16'h07D1, 12);
    run_silent(1'b0, 8'h00);
    mk(16'h0204, station_id, 8'h02, 16'h0001, 16'h0008, 11);
    run_silent(1'b0, 8'h00);
    mk(16'h0205, station_id, 8'h05, 16'h0001, 16'h0001, 8);
    run_silent(1'b1, 8'h05);
    mk(16'h0206, station_id, 8'h08, 16'h0001, 16'h0001, 7);
    run_silent(1'b0, 8'h00);
    close_out();
  end
endmodule // testbench
